/* File: rtl/qdt_regs.sv */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`include "qdt_map.svh"

// Function
// (RULE1) integral divider field selects listed divide factors
// (RULE2) proportional divider field selects listed divide factors
// (RULE3) leave quiet decay at programmed exit frequency
// (RULE4) compare against coil current waveform frequency
// (RULE5) exit threshold resets to all ones
// (RULE6) software never writes zero exit threshold
// (RULE7) enable bit switches quiet decay, resets off
// (RULE8) raw integral gain seven bits, resets zero
// (RULE9) codes 111 behave like 110, undivided
module qdt_regs #(
    parameter int ADR_W  = 10,  // wishbone byte address width
    parameter int FREQ_W = 10   // coil waveform frequency width, hertz
) (
    input  wire logic                  core_clk,         // core clock, 100 MHz
    input  wire logic                  reset_n,          // async reset, active low
    input  wire logic                  wb_cyc_i,         // wishbone cycle
    input  wire logic                  wb_stb_i,         // wishbone strobe
    input  wire logic                  wb_we_i,          // wishbone write enable
    input  wire logic [ADR_W-1:0]      wb_adr_i,         // wishbone byte address
    input  wire logic [3:0]            wb_sel_i,         // wishbone byte selects
    input  wire logic [31:0]           wb_dat_i,         // wishbone write data
    output logic      [31:0]           wb_dat_o,         // wishbone read data
    output logic                       wb_ack_o,         // wishbone acknowledge
    input  wire logic [FREQ_W-1:0]     coil_wave_freq,   // sine current frequency, Hz
    output logic                       quiet_enable,     // quiet decay enabled
    output logic                       quiet_active,     // quiet decay regulating
    output logic                       fallback_active,  // fallback decay selected
    output logic      [15:0]           prop_gain_eff,    // scaled proportional gain
    output logic      [15:0]           integ_gain_eff    // scaled integral gain
);

    localparam int IDX_W = ADR_W - 2;  // word index width

    // the map needs index 0x36 and the threshold in hertz needs nine bits
    initial begin
        if (ADR_W < 10 || FREQ_W < 9) begin
            $error("qdt_regs: ADR_W below 10 or FREQ_W below 9");
        end
    end

    // word index compare, used by both read and write decode
    function automatic logic idx_hit(input logic [IDX_W-1:0] idx, input logic [7:0] target);
        return idx == IDX_W'(target);
    endfunction

    logic [7:0]        ctrl_reg;      // enable and quiet decay control byte
    logic [7:0]        kp_raw_reg;    // raw proportional gain byte
    logic [7:0]        ki_raw_reg;    // raw integral gain byte
    logic [7:0]        div_reg;       // gain divider selects
    logic [7:0]        thr_reg;       // exit threshold, 2 Hz per count
    logic              ack_reg;       // acknowledge flop
    logic [31:0]       rdata_reg;     // read data flop
    logic [31:0]       rdata_next;    // read data mux
    logic [IDX_W-1:0]  idx;           // addressed word
    logic              req_new;       // fresh request this cycle
    logic              wr_en;         // write to low byte lane
    logic [FREQ_W-1:0] thr_hz;        // threshold in hertz
    logic              at_exit;       // waveform at or above threshold
    qdt_pkg::qdt_mode_t mode_reg;     // current regulation mode
    qdt_pkg::qdt_mode_t mode_next;    // next regulation mode

    assign idx     = wb_adr_i[ADR_W-1:2];
    assign req_new = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_en   = req_new && wb_we_i && wb_sel_i[0];

    // acknowledge one cycle after the request, dropped the cycle after
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req_new;
        end
    end

    // control byte, enable bit in bit 0
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `QDT_RST_ZERO; // [RULE7]
        end else if (wr_en && idx_hit(idx, `QDT_IDX_CTRL)) begin
            ctrl_reg <= wb_dat_i[7:0];
        end
    end

    // raw gain bytes, only the low seven bits feed the scalers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            kp_raw_reg <= `QDT_RST_ZERO;
            ki_raw_reg <= `QDT_RST_ZERO; // [RULE8]
        end else if (wr_en && idx_hit(idx, `QDT_IDX_KP_RAW)) begin
            kp_raw_reg <= wb_dat_i[7:0];
        end else if (wr_en && idx_hit(idx, `QDT_IDX_KI_RAW)) begin
            ki_raw_reg <= wb_dat_i[7:0];
        end
    end

    // divider selects, reserved bits kept as written
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= `QDT_RST_ZERO;
        end else if (wr_en && idx_hit(idx, `QDT_IDX_DIV)) begin
            div_reg <= wb_dat_i[7:0];
        end
    end

    // exit threshold; a zero here would force fallback at all speeds
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            thr_reg <= `QDT_RST_THR; // [RULE5]
        end else if (wr_en && idx_hit(idx, `QDT_IDX_THR)) begin
            thr_reg <= wb_dat_i[7:0]; // [RULE6]
        end
    end

    // read mux, unmapped words read as zero
    always_comb begin
        rdata_next = '0;
        if (idx_hit(idx, `QDT_IDX_CTRL)) begin
            rdata_next[7:0] = ctrl_reg;
        end else if (idx_hit(idx, `QDT_IDX_KP_RAW)) begin
            rdata_next[7:0] = kp_raw_reg;
        end else if (idx_hit(idx, `QDT_IDX_KI_RAW)) begin
            rdata_next[7:0] = ki_raw_reg;
        end else if (idx_hit(idx, `QDT_IDX_DIV)) begin
            rdata_next[7:0] = div_reg;
        end else if (idx_hit(idx, `QDT_IDX_THR)) begin
            rdata_next[7:0] = thr_reg;
        end else if (idx_hit(idx, `QDT_IDX_STATUS)) begin
            rdata_next[`QDT_STAT_QUIET_BIT] = quiet_active;
            rdata_next[`QDT_STAT_FALL_BIT]  = fallback_active;
        end
    end

    // read data captured with the acknowledge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else if (req_new && !wb_we_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;

    // threshold in hertz against the sine current frequency
    assign thr_hz  = FREQ_W'(thr_reg) * FREQ_W'(`QDT_HZ_PER_COUNT); // [RULE3]
    assign at_exit = coil_wave_freq >= thr_hz; // [RULE4]

    // mode selection from enable and waveform frequency
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            qdt_pkg::QDT_MODE_OFF: begin
                if (ctrl_reg[`QDT_EN_BIT]) begin
                    mode_next = at_exit ? qdt_pkg::QDT_MODE_FALLBACK : qdt_pkg::QDT_MODE_QUIET;
                end
            end
            qdt_pkg::QDT_MODE_QUIET: begin
                if (!ctrl_reg[`QDT_EN_BIT]) begin
                    mode_next = qdt_pkg::QDT_MODE_OFF; // [RULE7]
                end else if (at_exit) begin
                    mode_next = qdt_pkg::QDT_MODE_FALLBACK; // [RULE3]
                end
            end
            qdt_pkg::QDT_MODE_FALLBACK: begin
                if (!ctrl_reg[`QDT_EN_BIT]) begin
                    mode_next = qdt_pkg::QDT_MODE_OFF; // [RULE7]
                end else if (!at_exit) begin
                    mode_next = qdt_pkg::QDT_MODE_QUIET; // [RULE4]
                end
            end
            default: begin
                mode_next = qdt_pkg::QDT_MODE_OFF;
            end
        endcase
    end

    // mode state flop
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= qdt_pkg::QDT_MODE_OFF;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign quiet_enable    = ctrl_reg[`QDT_EN_BIT];
    assign quiet_active    = mode_reg == qdt_pkg::QDT_MODE_QUIET;
    assign fallback_active = mode_reg == qdt_pkg::QDT_MODE_FALLBACK;

    // proportional gain scaler
    qdt_gain_scale #(
        .RAW_W  (7),
        .FRAC_W (`QDT_FRAC_W)
    ) u_prop_scale (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .raw_i    (kp_raw_reg[`QDT_GAIN_MSB:0]),
        .sel_i    (div_reg[`QDT_KP_SEL_LSB +: `QDT_SEL_W]),
        .gain_o   (prop_gain_eff)
    );

    // integral gain scaler
    qdt_gain_scale #(
        .RAW_W  (7),
        .FRAC_W (`QDT_FRAC_W)
    ) u_integ_scale (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .raw_i    (ki_raw_reg[`QDT_GAIN_MSB:0]),
        .sel_i    (div_reg[`QDT_KI_SEL_LSB +: `QDT_SEL_W]),
        .gain_o   (integ_gain_eff)
    );

    // expected gains for checking, by an explicit divide table
    logic [15:0] exp_kp;  // expected scaled proportional gain
    logic [15:0] exp_ki;  // expected scaled integral gain

    function automatic logic [15:0] ref_gain(input logic [6:0] raw, input logic [2:0] code);
        logic [15:0] full;
        full = {raw, 9'h000};
        case (code)
            3'h0:    return full / 16'h0020;
            3'h1:    return full / 16'h0040;
            3'h2:    return full / 16'h0080;
            3'h3:    return full / 16'h0100;
            3'h4:    return full / 16'h0200;
            3'h5:    return full / 16'h0010;
            default: return full;
        endcase
    endfunction

    assign exp_kp = ref_gain(kp_raw_reg[6:0], div_reg[2:0]);
    assign exp_ki = ref_gain(ki_raw_reg[6:0], div_reg[6:4]);

    // the register side right after reset release
    property p_reset_values;
        @(posedge core_clk) $rose(reset_n) |->
            (thr_reg == 8'hff) && (ki_raw_reg == 8'h00) && (mode_reg == qdt_pkg::QDT_MODE_OFF);
    endproperty

    AST_THR_RESET: assert property (p_reset_values) // [RULE5]
        else $error("threshold or gains wrong after reset");

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence seq_exit_cond;
        ctrl_reg[0] && (coil_wave_freq >= FREQ_W'({thr_reg, 1'b0}));
    endsequence

    sequence seq_below_cond;
        ctrl_reg[0] && (coil_wave_freq < FREQ_W'({thr_reg, 1'b0}));
    endsequence

    AST_QUIET_EXIT: assert property (seq_exit_cond |=> fallback_active && !quiet_active) // [RULE3]
        else $error("no fallback at exit frequency");

    AST_QUIET_STAY: assert property (seq_below_cond |=> quiet_active && !fallback_active) // [RULE4]
        else $error("quiet decay left below exit frequency");

    AST_ENABLE_OFF: assert property (!ctrl_reg[0] |=> !quiet_active && !fallback_active) // [RULE7]
        else $error("decay mode active while disabled");

    AST_GAIN_RANGE: assert property ( // [RULE8]
        (div_reg[`QDT_KI_SEL_LSB +: `QDT_SEL_W] == `QDT_SEL_NONE) |=>
        (integ_gain_eff[15:`QDT_FRAC_W] == $past(ki_raw_reg[`QDT_GAIN_MSB:0])))
        else $error("raw integral gain not passed through as seven bits");

    AST_KI_SCALE: assert property (1'b1 |=> integ_gain_eff == $past(exp_ki)) // [RULE1]
        else $error("integral gain divider wrong");

    AST_KP_SCALE: assert property (1'b1 |=> prop_gain_eff == $past(exp_kp)) // [RULE2]
        else $error("proportional gain divider wrong");

    AST_WB_ACK: assert property (req_new |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not a single cycle");

endmodule

/* File: rtl/qdt_map.svh */
`ifndef QDT_MAP_SVH
`define QDT_MAP_SVH

// register indices; byte address is four times the index
`define QDT_IDX_CTRL        8'h31
`define QDT_IDX_KP_RAW      8'h32
`define QDT_IDX_KI_RAW      8'h33
`define QDT_IDX_DIV         8'h34
`define QDT_IDX_THR         8'h35
`define QDT_IDX_STATUS      8'h36

// reset values
`define QDT_RST_ZERO        8'h00
`define QDT_RST_THR         8'hff

// field positions
`define QDT_EN_BIT          0
`define QDT_GAIN_MSB        6
`define QDT_KP_SEL_LSB      0
`define QDT_KI_SEL_LSB      4
`define QDT_SEL_W           3
`define QDT_STAT_QUIET_BIT  0
`define QDT_STAT_FALL_BIT   1

// divider select codes
`define QDT_SEL_DIV32       3'h0
`define QDT_SEL_DIV64       3'h1
`define QDT_SEL_DIV128      3'h2
`define QDT_SEL_DIV256      3'h3
`define QDT_SEL_DIV512      3'h4
`define QDT_SEL_DIV16       3'h5
`define QDT_SEL_NONE        3'h6

// right shifts that each divider select code applies
`define QDT_SHIFT_DIV32     4'h5
`define QDT_SHIFT_DIV64     4'h6
`define QDT_SHIFT_DIV128    4'h7
`define QDT_SHIFT_DIV256    4'h8
`define QDT_SHIFT_DIV512    4'h9
`define QDT_SHIFT_DIV16     4'h4
`define QDT_SHIFT_NONE      4'h0

// fractional bits of the scaled gains, enough for the largest divider
`define QDT_FRAC_W          9
// exit threshold scale in hertz per count
`define QDT_HZ_PER_COUNT    2

`endif

/* File: rtl/qdt_pkg.sv */
`include "qdt_map.svh"

package qdt_pkg;

    // regulation mode seen by the decay logic
    typedef enum logic [1:0] {
        QDT_MODE_OFF,
        QDT_MODE_QUIET,
        QDT_MODE_FALLBACK
    } qdt_mode_t;

    // divider select code to right shift; codes 110 and 111 pass the raw gain
    function automatic logic [3:0] qdt_div_shift(input logic [2:0] code);
        case (code)
            `QDT_SEL_DIV32:  return `QDT_SHIFT_DIV32;
            `QDT_SEL_DIV64:  return `QDT_SHIFT_DIV64;
            `QDT_SEL_DIV128: return `QDT_SHIFT_DIV128;
            `QDT_SEL_DIV256: return `QDT_SHIFT_DIV256;
            `QDT_SEL_DIV512: return `QDT_SHIFT_DIV512;
            `QDT_SEL_DIV16:  return `QDT_SHIFT_DIV16;
            default:         return `QDT_SHIFT_NONE;
        endcase
    endfunction

endpackage

/* File: rtl/qdt_gain_scale.sv */
`timescale 1ns/10ps
`include "qdt_map.svh"

module qdt_gain_scale #(
    parameter int RAW_W  = 7,
    parameter int FRAC_W = `QDT_FRAC_W
) (
    input  wire logic                    core_clk,  // core clock
    input  wire logic                    reset_n,   // async reset, active low
    input  wire logic [RAW_W-1:0]        raw_i,     // raw gain
    input  wire logic [`QDT_SEL_W-1:0]   sel_i,     // divider select code
    output logic      [RAW_W+FRAC_W-1:0] gain_o     // scaled gain, fixed point
);

    // the largest divider must not lose bits below the fraction
    initial begin
        if (FRAC_W < `QDT_FRAC_W || RAW_W < 1) begin
            $error("qdt_gain_scale: FRAC_W too small or RAW_W empty");
        end
    end

    logic [RAW_W+FRAC_W-1:0] scaled;  // raw gain placed over the fraction, then shifted

    // divide by a power of two as a right shift
    always_comb begin
        scaled = {raw_i, {FRAC_W{1'b0}}} >> qdt_pkg::qdt_div_shift(sel_i); // [RULE1] [RULE2] [RULE9]
    end

    // registered so the regulator sees a stable gain
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_o <= '0;
        end else begin
            gain_o <= scaled;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // undocumented code 111 behaves like 110: raw gain undivided
    AST_UNDOC_CODE: assert property ( // [RULE9]
        (sel_i == 3'h7) |=> (gain_o == {$past(raw_i), {FRAC_W{1'b0}}}))
        else $error("code 111 did not pass the raw gain");

endmodule

/* File: verification/qdt_regs_tb.sv */
`timescale 1ns/10ps
`include "qdt_map.svh"

// compare one design value with its expectation and count the outcome
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module qdt_regs_tb;
    logic        core_clk;         // core clock, 100 MHz
    logic        reset_n;          // async reset, active low
    logic        wb_cyc_i;         // bus cycle
    logic        wb_stb_i;         // bus strobe
    logic        wb_we_i;          // bus write enable
    logic [9:0]  wb_adr_i;         // bus byte address
    logic [3:0]  wb_sel_i;         // bus byte selects
    logic [31:0] wb_dat_i;         // bus write data
    logic [31:0] wb_dat_o;         // bus read data
    logic        wb_ack_o;         // bus acknowledge
    logic [9:0]  coil_wave_freq;   // coil waveform frequency, Hz
    logic        quiet_enable;     // enable bit out
    logic        quiet_active;     // quiet decay flag
    logic        fallback_active;  // fallback decay flag
    logic [15:0] prop_gain_eff;    // scaled proportional gain
    logic [15:0] integ_gain_eff;   // scaled integral gain
    int          fails;            // mismatch count
    int          checks_done;      // comparison count
    int          sh_tab [8] = '{5, 6, 7, 8, 9, 4, 0, 0};  // right shift per select code

    qdt_regs dut_u (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .wb_cyc_i        (wb_cyc_i),
        .wb_stb_i        (wb_stb_i),
        .wb_we_i         (wb_we_i),
        .wb_adr_i        (wb_adr_i),
        .wb_sel_i        (wb_sel_i),
        .wb_dat_i        (wb_dat_i),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .coil_wave_freq  (coil_wave_freq),
        .quiet_enable    (quiet_enable),
        .quiet_active    (quiet_active),
        .fallback_active (fallback_active),
        .prop_gain_eff   (prop_gain_eff),
        .integ_gain_eff  (integ_gain_eff)
    );

    // free running clock
    always #5 core_clk = ~core_clk;

    // print counts and verdict, then stop
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one classic bus cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] sel, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 20) begin
            fails++;
            $display("[FAIL] ack expected 1 seen timeout");
        end
    endtask

    // register write with the low byte selected
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'h1, q);
    endtask

    // register read
    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        wb(1'b0, idx, 8'h00, 4'hf, q);
    endtask

    // let registered outputs follow their inputs
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // new coil frequency, then the three mode outputs and status
    task automatic chk_mode(input logic [9:0] f, input logic en, input logic qa,
                            input logic fb);
        logic [31:0] q;
        @(posedge core_clk);
        coil_wave_freq <= f;
        settle;
        `CHK("quiet_enable", en, quiet_enable)
        `CHK("quiet_active", qa, quiet_active)
        `CHK("fallback_active", fb, fallback_active)
        rd(`QDT_IDX_STATUS, q);
        `CHK("status", {30'h0, fb, qa}, q)
    endtask

    // pulse reset, then ctrl, ki_raw, div and thr back to their reset values
    task automatic t_reset;
        logic [31:0] q;
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`QDT_IDX_CTRL, q);
        `CHK("ctrl", 32'h00000000, q)
        rd(`QDT_IDX_KI_RAW, q);
        `CHK("ki_raw", 32'h00000000, q)
        rd(`QDT_IDX_DIV, q);
        `CHK("div", 32'h00000000, q)
        rd(`QDT_IDX_THR, q);
        `CHK("thr", 32'h000000ff, q)
        `CHK("integ_gain_eff", 16'h0000, integ_gain_eff)
        `CHK("quiet_enable", 1'b0, quiet_enable)
    endtask

    // every divider code on both fields, opposite codes at once
    task automatic t_gain;
        logic [31:0] q;
        logic [15:0] ep;
        logic [15:0] ei;
        wr(`QDT_IDX_KP_RAW, 8'hff);
        wr(`QDT_IDX_KI_RAW, 8'h55);
        rd(`QDT_IDX_KI_RAW, q);
        `CHK("ki_raw", 32'h00000055, q)
        for (int c = 0; c < 8; c++) begin
            wr(`QDT_IDX_DIV, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
            settle;
            ei = {7'h55, 9'h000} >> sh_tab[c];
            ep = {7'h7f, 9'h000} >> sh_tab[7 - c];
            `CHK("integ_gain_eff", ei, integ_gain_eff)
            `CHK("prop_gain_eff", ep, prop_gain_eff)
        end
    endtask

    // exit threshold edges at a low and at the full-scale setting
    task automatic t_mode;
        wr(`QDT_IDX_THR, 8'h10); // nonzero threshold only
        chk_mode(10'd100, 1'b0, 1'b0, 1'b0);
        wr(`QDT_IDX_CTRL, 8'h01);
        chk_mode(10'd100, 1'b1, 1'b0, 1'b1);
        chk_mode(10'd31, 1'b1, 1'b1, 1'b0);
        chk_mode(10'd32, 1'b1, 1'b0, 1'b1);
        chk_mode(10'd1, 1'b1, 1'b1, 1'b0);
        wr(`QDT_IDX_THR, 8'hff); // nonzero threshold only
        chk_mode(10'd509, 1'b1, 1'b1, 1'b0);
        chk_mode(10'd510, 1'b1, 1'b0, 1'b1);
        wr(`QDT_IDX_CTRL, 8'h00);
        chk_mode(10'd100, 1'b0, 1'b0, 1'b0);
    endtask

    // unmapped place, unselected byte and read-only status
    task automatic t_bus;
        logic [31:0] q;
        wr(8'h20, 8'h5a);
        rd(8'h20, q);
        `CHK("unmapped", 32'h00000000, q)
        wb(1'b1, `QDT_IDX_THR, 8'h22, 4'he, q);
        rd(`QDT_IDX_THR, q);
        `CHK("thr_no_sel", 32'h000000ff, q)
        wr(`QDT_IDX_STATUS, 8'hff);
        rd(`QDT_IDX_STATUS, q);
        `CHK("status_ro", 32'h00000000, q)
    endtask

    // main sequence
    initial begin
        core_clk       = 1'b0;
        reset_n        = 1'b0;
        wb_cyc_i       = 1'b0;
        wb_stb_i       = 1'b0;
        wb_we_i        = 1'b0;
        wb_adr_i       = 10'h000;
        wb_sel_i       = 4'h0;
        wb_dat_i       = 32'h00000000;
        coil_wave_freq = 10'h000;
        fails          = 0;
        checks_done    = 0;
        t_reset;
        t_gain;
        t_mode;
        t_bus;
        t_reset;
        close_out;
    end

    // watchdog against a hung handshake
    initial begin
        #200us;
        fails++;
        close_out;
    end
endmodule
